// >>> logic/tpc_defs.svh
// Register map, field positions and codes for the timer channel
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
`define TPC_ADDR_SC 8'h00
`define TPC_ADDR_VH 8'h04
`define TPC_ADDR_VL 8'h08
`define TPC_BIT_FLAG 7
`define TPC_BIT_IE 6
`define TPC_BIT_MSH 5
`define TPC_BIT_MSL 4
`define TPC_BIT_ELH 3
`define TPC_BIT_ELL 2
`define TPC_MS_IC 2'h0
`define TPC_ELS_OFF 2'h0
`define TPC_ELS_TOG 2'h1
`define TPC_ELS_CLR 2'h2
`define TPC_ELS_SET 2'h3
`define TPC_RST_VAL 16'h0000
`define TPC_RST_CTRL 2'h0
`define TPC_RESP_OK 2'h0
`define TPC_RESP_ERR 2'h2
`endif

// >>> logic/tpc_pkg.sv
// Types shared by the timer channel design
`default_nettype none
package tpc_pkg;
    // Resolved channel function, one-hot
    typedef enum logic [4:0] {
        TPC_OFF  = 5'b00001,
        TPC_IC   = 5'b00010,
        TPC_OC   = 5'b00100,
        TPC_EPWM = 5'b01000,
        TPC_CPWM = 5'b10000
    } tpc_mode_t;
endpackage
`default_nettype wire

// >>> logic/tpc_channel.sv
// One capture/compare/PWM channel with an AXI4-Lite register slave
//
// Summary of operation
// RULE1: Flag bit 7 sets on capture event or counter equal to value.
// RULE2: Center-aligned mode sets flag on every match, both duty edges.
// RULE3: Interrupt request is high while flag and enable are both set.
// RULE4: Flag clears only after read-while-set then write of 0.
// RULE5: New event during the clear sequence restarts it; flag stays set.
// RULE6: Reset clears flag; writing 1 to flag does nothing.
// RULE7: Bit 6 is interrupt enable, reset to 0; 0 means polling.
// RULE8: Without center mode, mode bit 5 set selects edge-aligned PWM.
// RULE9: Without center mode and bit 5 clear, bit 4 picks capture/compare.
// RULE10: Edge/level 00 releases the pin from timer use in every mode.
// RULE11: Capture edge: 01 rising, 10 falling, 11 either.
// RULE12: Compare action: 00 flag only, 01 toggle, 10 clear, 11 set.
// RULE13: Edge PWM: 10 high-true clear on compare, X1 low-true set.
// RULE14: Center PWM: 10 clears on up match, X1 sets on up match.
// RULE15: Software keeps pin stable two cycles before entering capture.
// RULE16: Software clears flags after reconfiguring, before using them.
// RULE17: Value holds capture or compare value; reset clears it.
// RULE18: In capture, reading one byte freezes both until other read.
// RULE19: Any control register write releases the frozen read buffer.
// RULE20: Compare/PWM byte writes buffer; value loads once both written.
// RULE21: Control register write drops a half-written value pair.
// RULE22: Active capture edge copies main counter into value register.
// RULE23: Center select forces center-aligned PWM regardless of mode bits.
// RULE24: Value appears as separate high and low byte registers.
`timescale 1ns/1ps
`include "tpc_defs.svh"
`default_nettype none
module tpc_channel
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Main counter, same clock domain
    input wire logic [15:0] i_main_counter,
    input wire logic i_cnt_tick,
    input wire logic i_cnt_wrap,
    input wire logic i_cnt_up,
    input wire logic i_center_aligned_select,
    // Channel pin
    input wire logic i_pin,
    output logic o_pin_out,
    output logic o_pin_oe,
    // Interrupt request
    output logic o_irq
);

    // Control and value state
    logic flag_q;
    logic ie_q;
    logic [1:0] ms_q;
    logic [1:0] els_q;
    logic armed_q;
    logic [15:0] value_q;
    logic [15:0] rbuf_q;
    logic rlatch_q;
    logic rfirst_hi_q;
    logic [7:0] wbuf_hi_q;
    logic [7:0] wbuf_lo_q;
    logic whave_hi_q;
    logic whave_lo_q;
    logic pin_q;
    logic pin_oe_q;
    logic irq_q;
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // Bus state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    tpc_mode_t mode;
    logic func_ic;
    logic wr_en;
    logic rd_en;
    logic wr_sc;
    logic wr_vh;
    logic wr_vl;
    logic rd_sc;
    logic rd_vh;
    logic rd_vl;
    logic rise;
    logic fall;
    logic match;
    logic cap_ev;
    logic cmp_ev;
    logic ev;
    logic clr_ok;
    logic pair_done;
    logic [15:0] pair_val;
    logic [7:0] sc_rd_val;

    // Channel function from the control fields
    always_comb begin
        if (els_q == `TPC_ELS_OFF) begin
            mode = TPC_OFF; // [RULE10]
        end else if (i_center_aligned_select) begin
            mode = TPC_CPWM; // [RULE23]
        end else if (ms_q[1]) begin
            mode = TPC_EPWM; // [RULE8]
        end else if (ms_q[0]) begin
            mode = TPC_OC; // [RULE9]
        end else begin
            mode = TPC_IC;
        end
    end

    // Capture function ignores the pin state bits; a software compare
    // with released pin still flags on match
    assign func_ic = !i_center_aligned_select && (ms_q == `TPC_MS_IC);

    // Access strobes; byte lane 0 must be enabled for a write to land
    assign wr_en = !awready_q && !wready_q && !bvalid_q;
    assign rd_en = i_arvalid && arready_q;
    assign wr_sc = wr_en && wstrb0_q && (awaddr_q == `TPC_ADDR_SC);
    assign wr_vh = wr_en && wstrb0_q && (awaddr_q == `TPC_ADDR_VH);
    assign wr_vl = wr_en && wstrb0_q && (awaddr_q == `TPC_ADDR_VL);
    assign rd_sc = rd_en && (i_araddr == `TPC_ADDR_SC);
    assign rd_vh = rd_en && (i_araddr == `TPC_ADDR_VH);
    assign rd_vl = rd_en && (i_araddr == `TPC_ADDR_VL);

    // Edge and match detection; only synchronised pin stages are used
    assign rise = sync2_q && !prev_q;
    assign fall = !sync2_q && prev_q;
    assign match = i_cnt_tick && (i_main_counter == value_q);
    assign cap_ev = (mode == TPC_IC)
        && ((els_q[0] && rise) || (els_q[1] && fall)); // [RULE11]
    assign cmp_ev = !func_ic && match; // [RULE1] [RULE2]
    assign ev = cap_ev || cmp_ev;
    assign clr_ok = wr_sc && !wdata_q[`TPC_BIT_FLAG] && armed_q;

    // Second byte of a buffered pair completes the word
    assign pair_done = !func_ic
        && ((wr_vh && whave_lo_q) || (wr_vl && whave_hi_q)); // [RULE20]
    assign pair_val = {wr_vh ? wdata_q : wbuf_hi_q,
        wr_vl ? wdata_q : wbuf_lo_q};
    assign sc_rd_val = {flag_q, ie_q, ms_q, els_q, 2'h0};

    // Pin synchroniser plus one history stage for edges
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Control bits other than the flag
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ie_q <= 1'b0; // [RULE7]
            ms_q <= `TPC_RST_CTRL;
            els_q <= `TPC_RST_CTRL;
        end else if (wr_sc) begin
            ie_q <= wdata_q[`TPC_BIT_IE]; // [RULE7]
            ms_q <= wdata_q[`TPC_BIT_MSH:`TPC_BIT_MSL];
            els_q <= wdata_q[`TPC_BIT_ELH:`TPC_BIT_ELL];
        end
    end

    // Event flag: a new event beats a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flag_q <= 1'b0; // [RULE6]
        end else if (ev) begin
            flag_q <= 1'b1; // [RULE1] [RULE5]
        end else if (clr_ok) begin
            flag_q <= 1'b0; // [RULE4]
        end
    end

    // Clear sequence arming; an event or any control register write disarms it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            armed_q <= 1'b0;
        end else if (ev || wr_sc) begin
            armed_q <= 1'b0; // [RULE5]
        end else if (rd_sc && flag_q) begin
            armed_q <= 1'b1; // [RULE4]
        end
    end

    // Interrupt request, one cycle behind the flag
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && ie_q; // [RULE3]
        end
    end

    // Value register: capture beats any software load
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            value_q <= `TPC_RST_VAL; // [RULE17]
        end else if (cap_ev) begin
            value_q <= i_main_counter; // [RULE22]
        end else if (pair_done) begin
            value_q <= pair_val; // [RULE20]
        end else if (func_ic && wr_vh) begin
            value_q[15:8] <= wdata_q;
        end else if (func_ic && wr_vl) begin
            value_q[7:0] <= wdata_q;
        end
    end

    // Write pairing buffer for compare and PWM modes
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wbuf_hi_q <= 8'h00;
            wbuf_lo_q <= 8'h00;
            whave_hi_q <= 1'b0;
            whave_lo_q <= 1'b0;
        end else if (wr_sc || pair_done) begin
            whave_hi_q <= 1'b0; // [RULE21]
            whave_lo_q <= 1'b0;
        end else if (!func_ic && wr_vh) begin
            wbuf_hi_q <= wdata_q;
            whave_hi_q <= 1'b1;
        end else if (!func_ic && wr_vl) begin
            wbuf_lo_q <= wdata_q;
            whave_lo_q <= 1'b1;
        end
    end

    // Read freeze buffer for capture mode
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rbuf_q <= `TPC_RST_VAL;
            rlatch_q <= 1'b0;
            rfirst_hi_q <= 1'b0;
        end else if (wr_sc) begin
            rlatch_q <= 1'b0; // [RULE19]
        end else if (func_ic && (rd_vh || rd_vl)) begin
            if (!rlatch_q) begin
                rbuf_q <= value_q; // [RULE18]
                rlatch_q <= 1'b1;
                rfirst_hi_q <= rd_vh;
            end else if (rd_vh != rfirst_hi_q) begin
                rlatch_q <= 1'b0;
            end
        end
    end

    // Pin driver; edge PWM compare beats the period start so 0% works
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_oe_q <= (mode == TPC_OC) || (mode == TPC_EPWM)
                || (mode == TPC_CPWM); // [RULE10]
            unique case (mode)
                TPC_OC: begin
                    if (match) begin
                        unique case (els_q) // [RULE12]
                            `TPC_ELS_TOG: pin_q <= !pin_q;
                            `TPC_ELS_CLR: pin_q <= 1'b0;
                            `TPC_ELS_SET: pin_q <= 1'b1;
                            `TPC_ELS_OFF: pin_q <= pin_q;
                        endcase
                    end
                end
                TPC_EPWM: begin
                    if (match) begin
                        pin_q <= els_q[0]; // [RULE13]
                    end else if (i_cnt_wrap) begin
                        pin_q <= !els_q[0]; // [RULE13]
                    end
                end
                TPC_CPWM: begin
                    if (match) begin
                        pin_q <= i_cnt_up ? els_q[0]
                            : !els_q[0]; // [RULE14]
                    end
                end
                TPC_OFF, TPC_IC: begin
                    pin_q <= pin_q;
                end
            endcase
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            awready_q <= 1'b1;
            awaddr_q <= 8'h00;
        end else if (i_awvalid && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q <= i_awaddr;
        end else if (bvalid_q && i_bready) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wready_q <= 1'b1;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (i_wvalid && wready_q) begin
            wready_q <= 1'b0;
            wdata_q <= i_wdata[7:0];
            wstrb0_q <= i_wstrb[0];
        end else if (bvalid_q && i_bready) begin
            wready_q <= 1'b1;
        end
    end

    // Write response once the write has taken effect
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `TPC_RESP_OK;
        end else if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == `TPC_ADDR_SC
                || awaddr_q == `TPC_ADDR_VH
                || awaddr_q == `TPC_ADDR_VL)
                ? `TPC_RESP_OK : `TPC_RESP_ERR;
        end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel; frozen bytes are served while the latch holds
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `TPC_RESP_OK;
        end else if (rd_en) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= `TPC_RESP_OK;
            if (rd_sc) begin
                rdata_q <= {24'h000000, sc_rd_val};
            end else if (rd_vh) begin
                rdata_q <= {24'h000000, rlatch_q ? rbuf_q[15:8]
                    : value_q[15:8]}; // [RULE24]
            end else if (rd_vl) begin
                rdata_q <= {24'h000000, rlatch_q ? rbuf_q[7:0]
                    : value_q[7:0]}; // [RULE24]
            end else begin
                rdata_q <= 32'h00000000;
                rresp_q <= `TPC_RESP_ERR;
            end
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Outputs straight from flip-flops
    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_pin_out = pin_q;
    assign o_pin_oe = pin_oe_q;
    assign o_irq = irq_q;

    // Checks on the channel behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_flag_on_event: assert property (ev |=> flag_q) // [RULE1]
        else $error("flag not set after event");
    a_center_flag: assert property (
        (mode == TPC_CPWM) && match |=> flag_q) // [RULE2]
        else $error("center match did not flag");
    a_irq_follows: assert property (
        flag_q && ie_q ##1 flag_q && ie_q |-> o_irq) // [RULE3]
        else $error("irq missing while flag enabled");
    a_flag_clear_seq: assert property (
        clr_ok && !ev |=> !flag_q) // [RULE4]
        else $error("flag not cleared by sequence");
    a_flag_sticky: assert property (
        flag_q && !clr_ok |=> flag_q) // [RULE5]
        else $error("flag dropped without clear");
    a_capture_load: assert property (
        cap_ev |=> value_q == $past(i_main_counter)) // [RULE22]
        else $error("capture value wrong");
    a_pin_release: assert property (
        els_q == `TPC_ELS_OFF |=> !o_pin_oe) // [RULE10]
        else $error("pin driven while released");
    a_pair_load: assert property (
        pair_done && !cap_ev |=> value_q == $past(pair_val)) // [RULE20]
        else $error("buffered pair not loaded");
    a_sc_unfreeze: assert property (wr_sc |=> !rlatch_q) // [RULE19]
        else $error("read latch kept after control write");

endmodule
`default_nettype wire

// >>> sim/tpc_pin_model.sv
// Channel pin partner: the timer drives it or an outside source does
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
    // Timer side of the pin
    input wire logic i_drive,
    input wire logic i_drive_oe,
    // Outside source level, used only while the timer lets go
    input wire logic i_ext_level,
    // Resolved pin level
    output logic o_pin
);
    // Timer output wins while enabled; otherwise the source holds the line
    assign o_pin = i_drive_oe ? i_drive : i_ext_level;
endmodule
`default_nettype wire

// >>> sim/tpc_channel_tb.sv
// Self-checking bench for the timer capture/compare channel
`timescale 1ns/1ps
`include "tpc_defs.svh"
`default_nettype none
module tpc_channel_tb;
    logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rd, rng;
    logic [3:0] i_wstrb;
    logic [15:0] i_main_counter, v, c, cap_q;
    logic i_cnt_tick, i_cnt_wrap, i_cnt_up, i_center_aligned_select;
    logic ext_level, i_pin, o_awready, o_wready, o_bvalid, o_arready;
    logic o_rvalid, o_pin_out, o_pin_oe, o_irq, pin_q, rise;
    logic [1:0] o_bresp, o_rresp, resp, els;
    logic [7:0] ctrl;
    logic [7:0] ord = 8'h1E;
    int miscompares, compares, k, e;

    tpc_channel uut (.i_clk(i_clk), .i_rst(i_rst), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .i_main_counter(i_main_counter),
        .i_cnt_tick(i_cnt_tick), .i_cnt_wrap(i_cnt_wrap),
        .i_cnt_up(i_cnt_up),
        .i_center_aligned_select(i_center_aligned_select),
        .i_pin(i_pin), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_irq(o_irq));
    tpc_pin_model pin (.i_drive(o_pin_out), .i_drive_oe(o_pin_oe),
        .i_ext_level(ext_level), .o_pin(i_pin));

    // 100 MHz clock
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Expected compare pin level after a match
    function automatic logic oc_pin(input logic [1:0] m, input logic p);
        return (m == `TPC_ELS_TOG) ? !p : (m == `TPC_ELS_SET);
    endfunction

    // Whether this edge direction triggers a capture
    function automatic logic cap_hit(input logic [1:0] m, input logic r);
        return r ? m[0] : m[1];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Write one register; each channel released when its ready is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw, w, b;
        int n;
        aw = 1'h1;
        w = 1'h1;
        b = 1'h0;
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_awaddr <= a;
        i_wdata <= {24'h000000, d};
        i_bready <= 1'h1;
        for (n = 0; n < 100 && !b; n++) begin
            @(posedge i_clk);
            aw = aw && !o_awready;
            w = w && !o_wready;
            b = o_bvalid;
            resp = o_bresp;
            i_awvalid <= aw;
            i_wvalid <= w;
            i_bready <= !b;
        end
        if (!b) begin
            miscompares++;
            tally_and_finish();
        end
        @(posedge i_clk);
    endtask

    // Read one register into rd and resp
    task automatic rdr(input logic [7:0] a);
        logic ar, r;
        int n;
        ar = 1'h1;
        r = 1'h0;
        i_arvalid <= 1'h1;
        i_araddr <= a;
        i_rready <= 1'h1;
        for (n = 0; n < 100 && !r; n++) begin
            @(posedge i_clk);
            ar = ar && !o_arready;
            r = o_rvalid;
            rd = o_rdata;
            resp = o_rresp;
            i_arvalid <= ar;
            i_rready <= !r;
        end
        if (!r) begin
            miscompares++;
            tally_and_finish();
        end
        @(posedge i_clk);
    endtask

    // One counter step; matches are only counted on a tick
    task automatic tick(input logic [15:0] cv, input logic w, input logic u);
        i_main_counter <= cv;
        i_cnt_tick <= 1'h1;
        i_cnt_wrap <= w;
        i_cnt_up <= u;
        @(posedge i_clk);
        i_cnt_tick <= 1'h0;
        i_cnt_wrap <= 1'h0;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic flag_is(input logic f);
        rdr(`TPC_ADDR_SC);
        chk(rd[7], f);
    endtask

    task automatic setval(input logic [15:0] nv);
        wr(`TPC_ADDR_VL, nv[7:0]);
        wr(`TPC_ADDR_VH, nv[15:8]);
    endtask

    // Capture on a pin change with a fresh counter value
    task automatic pin_to(input logic lvl, input logic [15:0] cv);
        i_main_counter <= cv;
        ext_level <= lvl;
        repeat (8) @(posedge i_clk);
    endtask

    initial begin
        i_rst = 1'h1;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        {i_awaddr, i_araddr, i_wdata} = 48'h0;
        i_wstrb = 4'hF;
        i_main_counter = 16'h0000;
        {i_cnt_tick, i_cnt_wrap, i_center_aligned_select} = 3'h0;
        i_cnt_up = 1'h1;
        ext_level = 1'h0;
        rng = 32'hD203C24A;
        miscompares = 0;
        compares = 0;
        pin_q = 1'h0;
        cap_q = 16'h0000;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'h0;
        @(posedge i_clk);
        // Reset values and an unmapped address
        rdr(`TPC_ADDR_SC);
        chk(rd, 32'h0);
        rdr(`TPC_ADDR_VH);
        chk(rd, 32'h0);
        rdr(`TPC_ADDR_VL);
        chk(rd, 32'h0);
        rdr(8'h0C);
        chk(resp, `TPC_RESP_ERR);
        // Unmapped write lands nowhere and answers with an error
        wr(8'h0C, 8'hFF);
        chk(resp, `TPC_RESP_ERR);
        $display("test reset done");
        // Compare actions: clear, set, toggle, flag only
        for (k = 0; k < 4; k++) begin
            els = ord[2*k +: 2];
            ctrl = {1'h0, k[0], 2'h1, els, 2'h0};
            rng = xs(rng);
            v = rng[15:0];
            wr(`TPC_ADDR_SC, ctrl);
            wr(`TPC_ADDR_VL, ~v[7:0]);
            wr(`TPC_ADDR_SC, ctrl);
            wr(`TPC_ADDR_VH, v[15:8]);
            wr(`TPC_ADDR_VL, v[7:0]);
            chk(resp, `TPC_RESP_OK);
            tick(v ^ 16'h0001, 1'h0, 1'h1);
            flag_is(1'h0);
            tick(v, 1'h0, 1'h1);
            flag_is(1'h1);
            chk(o_irq, k[0]);
            chk(o_pin_oe, els != `TPC_ELS_OFF);
            pin_q = oc_pin(els, pin_q);
            if (els != `TPC_ELS_OFF) chk(o_pin_out, pin_q);
            rdr(`TPC_ADDR_SC);
            tick(v, 1'h0, 1'h1);
            wr(`TPC_ADDR_SC, ctrl);
            flag_is(1'h1);
            wr(`TPC_ADDR_SC, ctrl | 8'h80);
            flag_is(1'h1);
            wr(`TPC_ADDR_SC, ctrl);
            flag_is(1'h0);
            chk(o_irq, 1'h0);
        end
        $display("test compare done");
        // Capture edges; pin held quiet before entering capture
        repeat (4) @(posedge i_clk);
        for (k = 1; k < 4; k++) begin
            ctrl = {4'h0, k[1:0], 2'h0};
            wr(`TPC_ADDR_SC, ctrl);
            rdr(`TPC_ADDR_SC);
            wr(`TPC_ADDR_SC, ctrl);
            for (e = 0; e < 2; e++) begin
                rise = (e == 0);
                rng = xs(rng);
                pin_to(rise, rng[15:0]);
                if (cap_hit(k[1:0], rise)) cap_q = rng[15:0];
                rdr(`TPC_ADDR_VL);
                chk(rd[7:0], cap_q[7:0]);
                rdr(`TPC_ADDR_VH);
                chk(rd[7:0], cap_q[15:8]);
                flag_is(cap_hit(k[1:0], rise));
                wr(`TPC_ADDR_SC, ctrl);
            end
        end
        // Frozen pair survives a capture, a control write frees it
        rdr(`TPC_ADDR_VL);
        c = cap_q ^ 16'hA500;
        pin_to(1'h1, c);
        rdr(`TPC_ADDR_VH);
        chk(rd[7:0], cap_q[15:8]);
        rdr(`TPC_ADDR_VL);
        wr(`TPC_ADDR_SC, ctrl);
        pin_to(1'h0, c ^ 16'h5A00);
        rdr(`TPC_ADDR_VH);
        chk(rd[7:0], c[15:8] ^ 8'h5A);
        $display("test capture done");
        // Edge-aligned PWM, both polarities
        for (k = 2; k > 0; k--) begin
            ctrl = {4'h2, k[1:0], 2'h0};
            wr(`TPC_ADDR_SC, ctrl);
            rng = xs(rng);
            v = rng[15:0] | 16'h0100;
            setval(v);
            tick(16'h0000, 1'h1, 1'h1);
            chk({o_pin_oe, o_pin_out}, {1'h1, k == 2});
            tick(v, 1'h0, 1'h1);
            chk({o_pin_oe, o_pin_out}, {1'h1, k != 2});
        end
        $display("test edge pwm done");
        // Center mode overrides capture mode bits
        i_center_aligned_select <= 1'h1;
        ctrl = {4'h0, `TPC_ELS_CLR, 2'h0};
        wr(`TPC_ADDR_SC, ctrl);
        setval(v);
        rdr(`TPC_ADDR_SC);
        wr(`TPC_ADDR_SC, ctrl);
        tick(v, 1'h0, 1'h1);
        chk({o_pin_oe, o_pin_out}, 2'h2);
        flag_is(1'h1);
        wr(`TPC_ADDR_SC, ctrl);
        tick(v, 1'h0, 1'h0);
        chk(o_pin_out, 1'h1);
        flag_is(1'h1);
        ctrl = {4'h0, `TPC_ELS_TOG, 2'h0};
        wr(`TPC_ADDR_SC, ctrl);
        tick(v, 1'h0, 1'h0);
        tick(v, 1'h0, 1'h1);
        chk(o_pin_out, 1'h1);
        $display("test center pwm done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
